// ==== hw/adcrc_pkg.sv ====
// Shared constants and types for the audio DAC clock and rate control block
package adcrc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] REG_CTRL_ZERO = 8'h00;
  localparam logic [7:0] REG_CTRL_ONE  = 8'h01;

  // Control register zero fields
  localparam int CZ_PLLREF_LSB = 6;
  localparam int CZ_MRS_LSB    = 1;
  localparam int CZ_PUP_BIT    = 0;
  localparam logic [7:0] CTRL_ZERO_RST = 8'h00;

  // Control register one fields
  localparam int CO_GPWR_LSB   = 6;
  localparam int CO_MCKO_LSB   = 4;
  localparam int CO_CLKSEL_BIT = 0;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h20;

  // Rate range field encodings
  localparam logic [1:0] RATE_48       = 2'h0;
  localparam logic [1:0] RATE_96       = 2'h1;
  localparam logic [1:0] RATE_LOW_LAT  = 2'h3;

  // Master clock output select encodings
  localparam logic [1:0] MCKO_LOW      = 2'h0;
  localparam logic [1:0] MCKO_HIGH     = 2'h1;
  localparam logic [1:0] MCKO_COPY     = 2'h2;
  localparam logic [1:0] MCKO_OFF      = 2'h3;

  // PLL reference encodings
  localparam logic [1:0] PLLREF_FRAME  = 2'h1;

  // Global power level value that defers to the per-channel fields
  localparam logic [1:0] GPWR_PER_CH   = 2'h0;

  // Ratios in the 48 kHz range
  localparam logic [9:0] OSR_48        = 10'h100;
  localparam logic [9:0] CORE_48       = 10'h200;
  localparam logic [9:0] DIRECT_RATIO  = 10'h200;
  // Master ratio select: 256, 384, 512, 768 (packed, entry 0 in low bits)
  localparam logic [39:0] MRS_TBL = {10'h300, 10'h200, 10'h180, 10'h100};

  // Output divider per master ratio select, keeping 4..6 MHz and 8..12 MHz
  localparam logic [11:0] DIV_LOW_TBL  = {3'h6, 3'h4, 3'h3, 3'h2};
  localparam logic [11:0] DIV_HIGH_TBL = {3'h3, 3'h2, 3'h2, 3'h1};

  // Attenuation: 255 steps of 0.375 dB, expressed in millidecibels
  localparam int NUM_CH          = 12;
  localparam logic [7:0] ATT_MAX_STEP = 8'hff;
  localparam logic [8:0] ATT_STEP_MDB = 9'h177;

  typedef enum logic [1:0] {RANGE_48K, RANGE_96K, RANGE_192K} adcrc_range_t;

endpackage : adcrc_pkg

// ==== hw/adcrc_rate_if.sv ====
// Rate configuration and derived ratios passed to the rate decoder
`timescale 1ns/1ps
interface adcrc_rate_if;
  logic [1:0] rate_field;
  logic [1:0] ratio_sel;
  logic [1:0] mcko_sel;
  logic [9:0] osr;
  logic [9:0] core_ratio;
  logic [9:0] eff_ratio;
  logic       low_latency;
  logic [2:0] mcko_div;
  adcrc_pkg::adcrc_range_t range;

  modport ctrl (output rate_field, ratio_sel, mcko_sel,
                input  osr, core_ratio, eff_ratio, low_latency, mcko_div, range);
  modport dec  (input  rate_field, ratio_sel, mcko_sel,
                output osr, core_ratio, eff_ratio, low_latency, mcko_div, range);
endinterface : adcrc_rate_if

// ==== hw/adcrc_rate_dec.sv ====
// Decodes rate range and ratio select into oversampling and clock ratios
`timescale 1ns/1ps
module adcrc_rate_dec (
  adcrc_rate_if.dec rif
);
  typedef struct packed {
    adcrc_pkg::adcrc_range_t range;
    logic [9:0]              base;
  } adcrc_dec_t;

  adcrc_dec_t d;

  always_comb begin
    d.base = adcrc_pkg::MRS_TBL[rif.ratio_sel*10 +: 10];
    case (rif.rate_field)
      adcrc_pkg::RATE_48: d.range = adcrc_pkg::RANGE_48K;
      adcrc_pkg::RATE_96: d.range = adcrc_pkg::RANGE_96K;
      default:            d.range = adcrc_pkg::RANGE_192K;
    endcase
    rif.range = d.range;
    case (d.range)
      adcrc_pkg::RANGE_48K: begin
        rif.osr        = adcrc_pkg::OSR_48;
        rif.core_ratio = adcrc_pkg::CORE_48;
        rif.eff_ratio  = d.base;
      end
      adcrc_pkg::RANGE_96K: begin
        rif.osr        = adcrc_pkg::OSR_48 >> 1;
        rif.core_ratio = adcrc_pkg::CORE_48 >> 1;
        rif.eff_ratio  = d.base >> 1;
      end
      default: begin
        rif.osr        = adcrc_pkg::OSR_48 >> 2;
        rif.core_ratio = adcrc_pkg::CORE_48 >> 2;
        rif.eff_ratio  = d.base >> 2;
      end
    endcase
    rif.low_latency = (rif.rate_field == adcrc_pkg::RATE_LOW_LAT);
    // Divider is picked from the ratio select, since that fixes the input frequency band
    case (rif.mcko_sel)
      adcrc_pkg::MCKO_LOW:  rif.mcko_div = adcrc_pkg::DIV_LOW_TBL[rif.ratio_sel*3 +: 3];
      adcrc_pkg::MCKO_HIGH: rif.mcko_div = adcrc_pkg::DIV_HIGH_TBL[rif.ratio_sel*3 +: 3];
      default:              rif.mcko_div = 3'h1;
    endcase
  end
endmodule : adcrc_rate_dec

// ==== hw/adcrc_mclk_div.sv ====
// Integer divider of the sampled master clock input
`timescale 1ns/1ps
module adcrc_mclk_div (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clk_in,
  input  wire logic [2:0] div,
  output logic            clk_out
);
  typedef struct packed {
    logic       prev;
    logic [2:0] cnt;
    logic       out;
  } adcrc_div_t;

  adcrc_div_t s_r;
  adcrc_div_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = clk_in;
    if (clk_in && !s_r.prev) begin
      s_nxt.cnt = (s_r.cnt >= div - 3'h1) ? 3'h0 : s_r.cnt + 3'h1;
    end
    // Divide by one is a plain copy; others run high for the first half
    if (div <= 3'h1) begin
      s_nxt.out = clk_in;
    end else begin
      s_nxt.out = (s_nxt.cnt < (div >> 1));
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clk_out = s_r.out;
endmodule : adcrc_mclk_div

// ==== hw/adcrc_top.sv ====
// Clock generation, rate and power-level control for a twelve-channel DAC
`timescale 1ns/1ps

// What this block does
// - Oversampling ratio 256, 128 or 64 by rate range.
// - Twelve channels each hold a 255-step attenuation in 0.375 dB steps.
// - Rate field 0b11 selects reduced-latency 192 kHz filtering.
// - Per-channel power field picks one of four bias levels.
// - Global power level resets to 0; nonzero overrides all channels.
// - In program mode after reset, master clock output copies the input.
// - Standalone-select level sampled at reset release picks the mode.
// - Output select resets to 0b10 copy; 0b11 disables the pin.
// - Settings 0b00 and 0b01 divide master clock into 4-6 or 8-12 MHz.
// - Both control registers are writable in program mode once the strap is taken.
// - Ratio select takes 256, 384, 512 or 768 times sample rate.
// - 96 kHz range halves, 192 kHz range quarters the effective ratio.
// - Core clock is 512, 256 or 128 times sample rate; PLL by default.
// - PLL is enabled out of reset without any write.
// - PLL off plus clock-source bit 1 gives direct 512x master clock.
// - PLL reference 0b01 locks to the frame clock, no master clock.
module adcrc_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        standalone_select,
  input  wire logic        master_clock_input,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [1:0]  rate_range,
  input  wire logic [23:0] channel_power_fields,
  input  wire logic        pll_power_down,
  input  wire logic        atten_wr,
  input  wire logic [3:0]  atten_ch,
  input  wire logic [7:0]  atten_step,
  output logic [7:0]       reg_rdata,
  output logic             standalone_active,
  output logic             master_clock_output,
  output logic             master_clock_output_en,
  output logic [9:0]       oversample_ratio,
  output logic [9:0]       core_ratio,
  output logic [9:0]       effective_ratio,
  output logic             low_latency,
  output logic             pll_enabled,
  output logic             pll_ref_frame,
  output logic             direct_mclk_mode,
  output logic             powered_up,
  output logic [23:0]      channel_bias_level,
  output logic [95:0]      channel_atten,
  output logic [16:0]      atten_mdb
);
  typedef struct packed {
    logic [7:0]  ctrl_zero;
    logic [7:0]  ctrl_one;
    logic        strap_taken;
    logic        standalone;
    logic [7:0]  rdata;
    logic        mcko;
    logic        mcko_en;
    logic [9:0]  osr;
    logic [9:0]  core;
    logic [9:0]  eff;
    logic        lowlat;
    logic        pll_en;
    logic        pll_frame;
    logic        direct;
    logic        pup;
    logic [23:0] bias;
    logic [95:0] atten;
    logic [16:0] mdb;
  } adcrc_state_t;

  adcrc_state_t s_r;
  adcrc_state_t s_nxt;
  logic [23:0]  bias_sel;
  logic         div_clk;

  adcrc_rate_if rif ();

  assign rif.rate_field = rate_range;
  assign rif.ratio_sel  = s_r.ctrl_zero[adcrc_pkg::CZ_MRS_LSB +: 2];
  assign rif.mcko_sel   = s_r.standalone ? adcrc_pkg::MCKO_COPY
                                         : s_r.ctrl_one[adcrc_pkg::CO_MCKO_LSB +: 2];

  adcrc_rate_dec u_dec (
    .rif (rif.dec)
  );

  adcrc_mclk_div u_div (
    .mclk    (mclk),
    .rst     (rst),
    .clk_in  (master_clock_input),
    .div     (rif.mcko_div),
    .clk_out (div_clk)
  );

  // Global level overrides every channel unless it is the per-channel value
  genvar ch;
  generate
    for (ch = 0; ch < adcrc_pkg::NUM_CH; ch++) begin : g_bias
      assign bias_sel[ch*2 +: 2] =
        (s_r.ctrl_one[adcrc_pkg::CO_GPWR_LSB +: 2] == adcrc_pkg::GPWR_PER_CH)
          ? channel_power_fields[ch*2 +: 2]
          : s_r.ctrl_one[adcrc_pkg::CO_GPWR_LSB +: 2];
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;

    // Strap is caught on the first clock after release, never under reset
    if (!s_r.strap_taken) begin
      s_nxt.strap_taken = 1'b1;
      s_nxt.standalone  = standalone_select;
    end

    // Writes ignored in standalone mode and until the strap has been taken
    if (reg_wr && s_r.strap_taken && !s_r.standalone) begin
      case (reg_addr)
        adcrc_pkg::REG_CTRL_ZERO: s_nxt.ctrl_zero = reg_wdata;
        adcrc_pkg::REG_CTRL_ONE:  s_nxt.ctrl_one  = reg_wdata;
        default: ;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        adcrc_pkg::REG_CTRL_ZERO: s_nxt.rdata = s_r.ctrl_zero;
        adcrc_pkg::REG_CTRL_ONE:  s_nxt.rdata = s_r.ctrl_one;
        default:                  s_nxt.rdata = 8'h00;
      endcase
    end

    // Master clock output path
    case (rif.mcko_sel)
      adcrc_pkg::MCKO_COPY: begin
        s_nxt.mcko    = master_clock_input;
        s_nxt.mcko_en = 1'b1;
      end
      adcrc_pkg::MCKO_OFF: begin
        s_nxt.mcko    = 1'b0;
        s_nxt.mcko_en = 1'b0;
      end
      default: begin
        s_nxt.mcko    = div_clk;
        s_nxt.mcko_en = 1'b1;
      end
    endcase

    // Ratios and filter mode
    s_nxt.osr    = rif.osr;
    s_nxt.core   = rif.core_ratio;
    s_nxt.lowlat = rif.low_latency;
    s_nxt.pup    = s_r.ctrl_zero[adcrc_pkg::CZ_PUP_BIT];

    // PLL on unless powered down, independent of register contents
    s_nxt.pll_en    = !pll_power_down;
    s_nxt.pll_frame = !pll_power_down &&
      (s_r.ctrl_zero[adcrc_pkg::CZ_PLLREF_LSB +: 2] == adcrc_pkg::PLLREF_FRAME);
    s_nxt.direct    = pll_power_down && s_r.ctrl_one[adcrc_pkg::CO_CLKSEL_BIT];
    // Direct mode expects 512x master clock; otherwise the selected ratio applies
    s_nxt.eff = s_nxt.direct ? (adcrc_pkg::DIRECT_RATIO >> rif.range)
                             : rif.eff_ratio;

    s_nxt.bias = bias_sel;

    // Attenuation steps saturate at the last step
    if (atten_wr && (atten_ch < 4'(adcrc_pkg::NUM_CH))) begin
      s_nxt.atten[atten_ch*8 +: 8] =
        (atten_step > adcrc_pkg::ATT_MAX_STEP) ? adcrc_pkg::ATT_MAX_STEP : atten_step;
    end
    if (atten_ch < 4'(adcrc_pkg::NUM_CH)) begin
      s_nxt.mdb = 17'(s_r.atten[atten_ch*8 +: 8]) * 17'(adcrc_pkg::ATT_STEP_MDB);
    end else begin
      s_nxt.mdb = 17'h00000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r           <= '0;
      s_r.ctrl_zero <= adcrc_pkg::CTRL_ZERO_RST;
      s_r.ctrl_one  <= adcrc_pkg::CTRL_ONE_RST;
      s_r.mcko_en   <= 1'b1;
      s_r.pll_en    <= 1'b1;
      s_r.osr       <= adcrc_pkg::OSR_48;
      s_r.core      <= adcrc_pkg::CORE_48;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata              = s_r.rdata;
  assign standalone_active      = s_r.standalone;
  assign master_clock_output    = s_r.mcko;
  assign master_clock_output_en = s_r.mcko_en;
  assign oversample_ratio       = s_r.osr;
  assign core_ratio             = s_r.core;
  assign effective_ratio        = s_r.eff;
  assign low_latency            = s_r.lowlat;
  assign pll_enabled            = s_r.pll_en;
  assign pll_ref_frame          = s_r.pll_frame;
  assign direct_mclk_mode       = s_r.direct;
  assign powered_up             = s_r.pup;
  assign channel_bias_level     = s_r.bias;
  assign channel_atten          = s_r.atten;
  assign atten_mdb              = s_r.mdb;
endmodule : adcrc_top

// ==== tb/adcrc_host_model.sv ====
// Far-side source of the master clock level, coherent with the block clock
`timescale 1ns/1ps
module adcrc_host_model (
  input  wire logic       mclk,
  input  wire logic [2:0] half,
  output logic            mclk_src
);
  logic [2:0] cnt;
  initial begin
    cnt = 3'h0;
    mclk_src = 1'b0;
  end
  // Toggles just after the block edge so the level is settled when sampled
  always @(posedge mclk) begin
    cnt <= (cnt + 3'h1 >= half) ? 3'h0 : cnt + 3'h1;
    if (cnt + 3'h1 >= half) mclk_src <= ~mclk_src;
  end
endmodule : adcrc_host_model

// ==== tb/adcrc_top_props.sv ====
// Concurrent checks on the ports of the clock and rate control block
`timescale 1ns/1ps
module adcrc_top_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [1:0] rate_range,
  input wire logic       pll_power_down,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       master_clock_output,
  input wire logic       master_clock_output_en,
  input wire logic [9:0] oversample_ratio,
  input wire logic [9:0] core_ratio,
  input wire logic       low_latency,
  input wire logic       pll_enabled,
  input wire logic       direct_mclk_mode
);
  logic [1:0] live_r;
  logic [1:0] sh_r;
  // Derived outputs are only trusted a few edges after reset release
  always_ff @(posedge mclk) begin
    live_r <= rst ? 2'h0 : (live_r == 2'h3 ? live_r : live_r + 2'h1);
    sh_r   <= rate_range[1] ? 2'h2 : {1'b0, rate_range[0]};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_osr_by_range: assert property (live_r == 2'h3 |-> oversample_ratio == (10'h100 >> sh_r))
    else $error("oversample ratio wrong for range");
  a_core_by_range: assert property (live_r == 2'h3 |-> core_ratio == (10'h200 >> sh_r))
    else $error("core ratio wrong for range");
  a_low_lat_flag: assert property (live_r == 2'h3 |-> low_latency == ($past(rate_range) == 2'h3))
    else $error("low latency flag wrong");
  a_pll_follows_pd: assert property (live_r == 2'h3 |-> pll_enabled == !$past(pll_power_down))
    else $error("pll enable does not follow power down");
  a_direct_needs_pd: assert property (live_r == 2'h3 && direct_mclk_mode |-> $past(pll_power_down))
    else $error("direct mode with pll running");
  a_off_pin_quiet: assert property (!master_clock_output_en |-> !master_clock_output)
    else $error("disabled clock output toggles");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (live_r == 2'h3 && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
  a_reset_state: assert property (disable iff (1'b0) rst |=> oversample_ratio == 10'h100
    && pll_enabled && master_clock_output_en && !direct_mclk_mode)
    else $error("wrong state after reset");
  c_low_lat: cover property (low_latency);
  c_direct: cover property (direct_mclk_mode);
  c_pin_off: cover property (!master_clock_output_en);
endmodule : adcrc_top_props

bind adcrc_top adcrc_top_props u_props (.mclk, .rst, .rate_range, .pll_power_down, .reg_rd,
  .reg_addr, .reg_rdata, .master_clock_output, .master_clock_output_en, .oversample_ratio,
  .core_ratio, .low_latency, .pll_enabled, .direct_mclk_mode);

// ==== tb/adcrc_top_bench.sv ====
// Self-checking bench for the clock and rate control block
`timescale 1ns/1ps
module adcrc_top_bench;
  logic mclk = 1'b0, rst = 1'b1, sa = 1'b0, mci, wr = 1'b0, rd = 1'b0, pd = 1'b0, awr = 1'b0;
  logic [7:0] addr = 8'h0, wdata = 8'h0, astep = 8'h0, rdata;
  logic [1:0] rate = 2'h0;
  logic [3:0] ach = 4'h0;
  logic [23:0] cpf = 24'h0, bias;
  logic [2:0] sel = 3'h7;
  logic [9:0] osr, core, eff;
  logic [95:0] catt, amod = 96'h0;
  logic [16:0] mdb;
  logic sa_act, mco, mco_en, ll, pll_en, pref, dmm, pup, mprev;
  logic [23:0] q[$];
  int err_count = 0, n_tests = 0, mrise = 0;
  int base[4] = '{256, 384, 512, 768}, lo[4] = '{2, 3, 4, 6}, hi[4] = '{1, 2, 2, 3};

  always #5 mclk = ~mclk;

  adcrc_host_model host (.mclk(mclk), .half(3'h1), .mclk_src(mci));

  adcrc_top dut (.mclk(mclk), .rst(rst), .standalone_select(sa), .master_clock_input(mci),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .rate_range(rate),
    .channel_power_fields(cpf), .pll_power_down(pd), .atten_wr(awr), .atten_ch(ach),
    .atten_step(astep), .reg_rdata(rdata), .standalone_active(sa_act),
    .master_clock_output(mco), .master_clock_output_en(mco_en), .oversample_ratio(osr),
    .core_ratio(core), .effective_ratio(eff), .low_latency(ll), .pll_enabled(pll_en),
    .pll_ref_frame(pref), .direct_mclk_mode(dmm), .powered_up(pup),
    .channel_bias_level(bias), .channel_atten(catt), .atten_mdb(mdb));

  function automatic logic [23:0] obs(input logic [2:0] s);
    case (s)
      3'h0: return {16'h0, rdata};
      3'h1: return {14'h0, osr};
      3'h2: return {14'h0, core};
      3'h3: return {14'h0, eff};
      3'h4: return {17'h0, ll, pll_en, pref, dmm, mco_en, sa_act, pup};
      3'h5: return bias;
      default: return {7'h0, mdb};
    endcase
  endfunction : obs

  // Oldest note is matched against whatever the probe selected
  always @(posedge mclk) begin
    mprev <= mco;
    if (mco === 1'b1 && mprev === 1'b0) mrise <= mrise + 1;
    if (sel != 3'h7) begin
      n_tests++;
      if (q.size() == 0 || obs(sel) !== q[0]) begin
        err_count++;
        $display("MISMATCH %0t probe %0d", $time, sel);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge mclk) wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) begin rd <= 1'b1; addr <= a; end
    @(posedge mclk) begin rd <= 1'b0; sel <= 3'h0; q.push_back({16'h0, e}); end
    @(posedge mclk) sel <= 3'h7;
  endtask : rreg

  task automatic probe(input logic [2:0] s, input logic [23:0] e);
    @(posedge mclk) begin sel <= s; q.push_back(e); end
    @(posedge mclk) sel <= 3'h7;
  endtask : probe

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    $display("MISMATCH %0t run did not finish", $time);
    end_sim();
  end

  initial begin
    int m, r, s, i, sh, c0, e;
    logic [7:0] st;
    logic [3:0] ch;
    void'($urandom(14));
    tick(12);
    rst <= 1'b0;
    tick(2);
    rreg(8'h00, 8'h00);
    rreg(8'h01, 8'h20);
    rreg(8'h05, 8'h00);
    probe(3'h4, 24'h24);
    for (m = 0; m < 4; m++) for (r = 0; r < 4; r++) begin
      wreg(8'h00, 8'(m * 2 + 1));
      @(posedge mclk) rate <= 2'(r);
      tick(3);
      sh = (r > 1) ? 2 : r;
      probe(3'h1, 24'(256 >> sh));
      probe(3'h2, 24'(512 >> sh));
      probe(3'h3, 24'(base[m] >> sh));
      probe(3'h4, {17'h0, r == 3, 6'h25});
    end
    @(posedge mclk) rate <= 2'h0;
    for (m = 0; m < 4; m++) for (s = 0; s < 4; s++) begin
      wreg(8'h00, 8'(m * 2 + 1));
      wreg(8'h01, 8'(s << 4));
      tick(8);
      c0 = mrise;
      tick(96);
      e = (s == 3) ? 0 : 48 / ((s == 0) ? lo[m] : (s == 1) ? hi[m] : 1);
      n_tests++;
      if (mrise - c0 > e + 1 || mrise - c0 + 1 < e) begin
        err_count++;
        $display("MISMATCH %0t clock out edges %0d", $time, mrise - c0);
      end
      probe(3'h4, {18'h0, 3'b100, s != 3, 2'b01});
    end
    @(posedge mclk) cpf <= 24'($urandom);
    for (s = 0; s < 4; s++) begin
      wreg(8'h01, 8'(s << 6) | 8'h20);
      tick(3);
      probe(3'h5, (s == 0) ? cpf : {12{2'(s)}});
    end
    for (i = 0; i < 8; i++) begin
      st = (i == 0) ? 8'hff : 8'($urandom);
      ch = (i == 0) ? 4'hb : 4'($urandom_range(13, 0));
      @(posedge mclk) begin awr <= 1'b1; ach <= ch; astep <= st; end
      if (ch < 12) amod[ch*8 +: 8] = st;
      @(posedge mclk) awr <= 1'b0;
      tick(2);
      n_tests++;
      if (catt !== amod) begin
        err_count++;
        $display("MISMATCH %0t attenuation store", $time);
      end
      probe(3'h6, (ch < 12) ? 24'(st * 375) : 24'h0);
    end
    wreg(8'h00, 8'h41);
    tick(3);
    probe(3'h4, 24'h35);
    @(posedge mclk) pd <= 1'b1;
    wreg(8'h01, 8'h21);
    tick(3);
    probe(3'h4, 24'h0d);
    probe(3'h3, 24'h200);
    @(posedge mclk) begin rst <= 1'b1; sa <= 1'b1; pd <= 1'b0; end
    tick(3);
    rst <= 1'b0;
    tick(2);
    wreg(8'h01, 8'h30);
    rreg(8'h01, 8'h20);
    probe(3'h4, 24'h26);
    tick(4);
    end_sim();
  end
endmodule : adcrc_top_bench
